/* File: hdl/rtm_ctrl.sv */
// Register bank and mode control for the RF transmit modulation path.
// Assumes an AHB-Lite master with single word transfers and an external FIFO byte source.
// Contract
// - Crystal select codes 000,001,011,100 give 12,12.8,16,19.2 MHz; others reserved.
// - Halve-select bit: 0 passes reference, 1 divides it by two.
// - Modulation bit: 0 OOK gates amplifier by bit, 1 FSK forces amplifier on.
// - FSK sends carrier plus deviation for one, minus deviation for zero.
// - OOK switches channel carrier on and off with each data bit.
// - Burst mode sends FIFO data by sequencer, then returns to standby.
// - Direct mode takes the direct bit; synth enable then transmitter enable.
// - Setting transmit-go starts a burst; software leaves settings alone meanwhile.
// - Hardware clears transmit-go at packet end and raises burst-complete request.
// - Writing zero to transmit-go aborts the running burst.
// - Deviation word is eleven bits: low eight and upper three.
// - Unimplemented bits ignore writes and read zero; here crystal control bits 6:5 keep written values and read back.
// - Direct transmit bit lives in bit 7 of FIFO control four.
// - Synth and transmitter enables act only in direct mode.
//
// Local design decisions: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
module rtm_ctrl #(
    parameter int BIT_CYC = rtm_pkg::RTM_BIT_CYC
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [7:0] fifo_data,
    input wire logic fifo_valid,
    input wire logic fifo_last,
    output logic fifo_pop,
    input wire logic irq_ack,
    output logic burst_done_irq,
    output rtm_pkg::rtm_afe_t afe
);
    import rtm_pkg::*;
    // ==========================================================
    // Register state.
    logic [2:0] crystal_freq_sel_r;
    logic ref_halve_sel_r;
    logic [1:0] xo_rsv_r;
    logic modulation_select_r;
    logic dir_mode_r;
    logic tx_go_r;
    logic [10:0] deviation_word_r;
    logic direct_tx_bit_r;
    logic synth_enable_ctl_r;
    logic tx_enable_ctl_r;
    logic irq_pend_r;
    // ==========================================================
    // Bus address phase capture.
    logic wr_pend_r;
    logic [7:0] addr_r;
    logic ap_valid;
    logic start_pulse;
    logic abort_pulse;
    logic bst_busy;
    logic bst_bit;
    logic bst_done;
    logic [7:0] wb;
    logic wr_oper;
    assign ap_valid = hsel && hready && htrans[1];
    assign wb = hwdata[7:0];
    assign wr_oper = wr_pend_r && (addr_r == RTM_OFF_OPER);
    // Start on a 0 to 1 write of transmit-go in burst mode.
    assign start_pulse = wr_oper && wb[RTM_OPER_GO_BIT] && !tx_go_r && !wb[RTM_OPER_DIR_BIT];
    assign abort_pulse = wr_oper && !wb[RTM_OPER_GO_BIT] && tx_go_r;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            addr_r <= 8'h00;
        end else begin
            wr_pend_r <= ap_valid && hwrite;
            if (ap_valid) begin
                addr_r <= haddr[7:0];
            end
        end
    end
    // ==========================================================
    // Crystal control register; reserved bits 6:5 take written values and read back.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            crystal_freq_sel_r <= RTM_XO_CTRL_RST[2:0];
            ref_halve_sel_r <= RTM_XO_CTRL_RST[3];
            xo_rsv_r <= RTM_XO_CTRL_RST[6:5];
        end else if (wr_pend_r && addr_r == RTM_OFF_XO_CTRL) begin
            crystal_freq_sel_r <= wb[RTM_CRYSTAL_FREQ_SEL_LSB +: 3];
            ref_halve_sel_r <= wb[RTM_XO_HALVE_BIT];
            xo_rsv_r <= wb[RTM_XO_RSV_LSB +: 2];
        end
    end
    // ==========================================================
    // Operation register; transmit-go cleared by hardware at burst end.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            modulation_select_r <= RTM_OPER_RST[RTM_OPER_FSK_BIT];
            dir_mode_r <= RTM_OPER_RST[RTM_OPER_DIR_BIT];
            tx_go_r <= RTM_OPER_RST[RTM_OPER_GO_BIT];
        end else begin
            if (wr_oper) begin
                modulation_select_r <= wb[RTM_OPER_FSK_BIT];
                dir_mode_r <= wb[RTM_OPER_DIR_BIT];
                tx_go_r <= wb[RTM_OPER_GO_BIT] && !wb[RTM_OPER_DIR_BIT];
            end else if (bst_done) begin
                tx_go_r <= 1'b0;
            end
        end
    end
    // ==========================================================
    // Deviation word, direct bit and direct-mode enables.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            deviation_word_r <= RTM_DEV_RST;
            direct_tx_bit_r <= 1'b0;
            synth_enable_ctl_r <= 1'b0;
            tx_enable_ctl_r <= 1'b0;
        end else if (wr_pend_r) begin
            unique case (addr_r)
                RTM_OFF_DEV_LO: deviation_word_r[7:0] <= wb;
                RTM_OFF_DEV_HI: deviation_word_r[10:8] <= wb[2:0];
                RTM_OFF_FIFO4: direct_tx_bit_r <= wb[RTM_FIFO4_DTX_BIT];
                RTM_OFF_OPMODE: begin
                    synth_enable_ctl_r <= wb[RTM_OPMODE_SX_BIT];
                    tx_enable_ctl_r <= wb[RTM_OPMODE_TX_BIT];
                end
                default: begin
                end
            endcase
        end
    end
    // ==========================================================
    // Burst-complete pending flag; a new completion wins over the acknowledge.
    logic ack_stat;
    assign ack_stat = wr_pend_r && addr_r == RTM_OFF_STATUS && wb[RTM_STAT_IRQ_BIT];
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_pend_r <= 1'b0;
        end else if (bst_done) begin
            irq_pend_r <= 1'b1;
        end else if (irq_ack || ack_stat) begin
            irq_pend_r <= 1'b0;
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            burst_done_irq <= 1'b0;
        end else begin
            burst_done_irq <= bst_done || (irq_pend_r && !(irq_ack || ack_stat));
        end
    end
    // ==========================================================
    // Burst sequencer.
    rtm_burst #(
        .BIT_CYC(BIT_CYC)
    ) u_burst (
        .hclk(hclk),
        .hresetn(hresetn),
        .start(start_pulse),
        .abort(abort_pulse),
        .fifo_data(fifo_data),
        .fifo_valid(fifo_valid),
        .fifo_last(fifo_last),
        .fifo_pop(fifo_pop),
        .busy(bst_busy),
        .tx_bit(bst_bit),
        .done(bst_done)
    );
    // ==========================================================
    // Front end drive.
    logic sel_bit;
    logic sel_synth;
    logic sel_tx;
    always_comb begin
        if (dir_mode_r) begin
            sel_bit = direct_tx_bit_r;
            sel_synth = synth_enable_ctl_r;
            sel_tx = synth_enable_ctl_r && tx_enable_ctl_r;
        end else begin
            sel_bit = bst_bit;
            sel_synth = bst_busy;
            sel_tx = bst_busy;
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            afe <= '0;
        end else begin
            afe.synth_en <= sel_synth;
            afe.pa_en <= sel_tx && (modulation_select_r || sel_bit);
            afe.tx_bit <= sel_bit;
            afe.fsk_mode <= modulation_select_r;
            afe.crystal_freq_sel <= crystal_freq_sel_r;
            afe.ref_halve_sel <= ref_halve_sel_r;
            afe.deviation_word <= deviation_word_r;
        end
    end
    // ==========================================================
    // Read data, one cycle after the address phase.
    logic [7:0] rd_byte;
    always_comb begin
        rd_byte = 8'h00;
        unique case (haddr[7:0])
            RTM_OFF_XO_CTRL: rd_byte = {1'b0, xo_rsv_r, 1'b0, ref_halve_sel_r, crystal_freq_sel_r};
            RTM_OFF_OPER: rd_byte = {2'b00, modulation_select_r, dir_mode_r, 3'b000, tx_go_r};
            RTM_OFF_DEV_LO: rd_byte = deviation_word_r[7:0];
            RTM_OFF_DEV_HI: rd_byte = {5'h00, deviation_word_r[10:8]};
            RTM_OFF_FIFO4: rd_byte = {direct_tx_bit_r, 7'h00};
            RTM_OFF_OPMODE: rd_byte = {6'h00, tx_enable_ctl_r, synth_enable_ctl_r};
            RTM_OFF_STATUS: rd_byte = {6'h00, bst_busy, irq_pend_r};
            default: rd_byte = 8'h00;
        endcase
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            if (ap_valid && !hwrite) begin
                hrdata <= {24'h00_0000, rd_byte};
            end
        end
    end
endmodule

/* File: hdl/rtm_pkg.sv */
// Package for the RF transmit mode and modulation control block.
// Assumes a 32-bit AHB-Lite register bus; registers sit in the low byte of each word.
package rtm_pkg;
    // ==========================================================
    // Register byte offsets
    localparam logic [7:0] RTM_OFF_XO_CTRL = 8'h00;
    localparam logic [7:0] RTM_OFF_OPER = 8'h04;
    localparam logic [7:0] RTM_OFF_DEV_LO = 8'h08;
    localparam logic [7:0] RTM_OFF_DEV_HI = 8'h0c;
    localparam logic [7:0] RTM_OFF_FIFO4 = 8'h10;
    localparam logic [7:0] RTM_OFF_OPMODE = 8'h14;
    localparam logic [7:0] RTM_OFF_STATUS = 8'h18;
    // ==========================================================
    // Field positions
    localparam int RTM_CRYSTAL_FREQ_SEL_LSB = 0;
    localparam int RTM_XO_HALVE_BIT = 3;
    localparam int RTM_XO_RSV_LSB = 5;
    localparam int RTM_OPER_GO_BIT = 0;
    localparam int RTM_OPER_DIR_BIT = 4;
    localparam int RTM_OPER_FSK_BIT = 5;
    localparam int RTM_FIFO4_DTX_BIT = 7;
    localparam int RTM_OPMODE_SX_BIT = 0;
    localparam int RTM_OPMODE_TX_BIT = 1;
    localparam int RTM_STAT_IRQ_BIT = 0;
    localparam int RTM_STAT_BUSY_BIT = 1;
    // ==========================================================
    // Reset values
    localparam logic [7:0] RTM_XO_CTRL_RST = 8'h23;
    localparam logic [7:0] RTM_OPER_RST = 8'h00;
    localparam logic [10:0] RTM_DEV_RST = 11'h190;
    // ==========================================================
    // Crystal codes
    localparam logic [2:0] RTM_XO_12M = 3'h0;
    localparam logic [2:0] RTM_XO_12M8 = 3'h1;
    localparam logic [2:0] RTM_XO_16M = 3'h3;
    localparam logic [2:0] RTM_XO_19M2 = 3'h4;
    // ==========================================================
    // Timing
    localparam int RTM_CLK_MHZ = 50;
    localparam int RTM_BIT_NS = 1000;
    localparam int RTM_BIT_CYC = (RTM_BIT_NS * RTM_CLK_MHZ) / 1000;
    typedef enum logic [1:0] {
        RTM_DST_UNTOUCHED,
        RTM_DST_OPER_WR
    } rtm_dummy_t;
    // ==========================================================
    // Analog front end controls
    typedef struct packed {
        logic synth_en;
        logic pa_en;
        logic tx_bit;
        logic fsk_mode;
        logic [2:0] crystal_freq_sel;
        logic ref_halve_sel;
        logic [10:0] deviation_word;
    } rtm_afe_t;
endpackage

/* File: hdl/rtm_burst.sv */
// Burst sequencer: shifts a packet from the FIFO, MSB first, one bit per bit period.
// Assumes the FIFO presents a byte with valid and takes it on pop.
`timescale 1ns/1ps
module rtm_burst #(
    parameter int BIT_CYC = rtm_pkg::RTM_BIT_CYC
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic start,
    input wire logic abort,
    input wire logic [7:0] fifo_data,
    input wire logic fifo_valid,
    input wire logic fifo_last,
    output logic fifo_pop,
    output logic busy,
    output logic tx_bit,
    output logic done
);
    import rtm_pkg::*;
    initial begin
        if (BIT_CYC < 1 || BIT_CYC > 65536) $error("BIT_CYC must be 1 to 65536");
    end
    typedef enum logic [1:0] {RTM_IDLE, RTM_LOAD, RTM_SHIFT} rtm_bst_t;
    rtm_bst_t st_r;
    logic [7:0] sh_r;
    logic [2:0] bit_r;
    logic last_r;
    logic [15:0] cnt_r;
    // ==========================================================
    // Sequencer.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_r <= RTM_IDLE;
            sh_r <= 8'h00;
            bit_r <= 3'h0;
            last_r <= 1'b0;
            cnt_r <= 16'h0000;
            fifo_pop <= 1'b0;
            done <= 1'b0;
            busy <= 1'b0;
            tx_bit <= 1'b0;
        end else begin
            fifo_pop <= 1'b0;
            done <= 1'b0;
            if (abort) begin
                st_r <= RTM_IDLE;
                busy <= 1'b0;
                tx_bit <= 1'b0;
            end else begin
                unique case (st_r)
                    RTM_IDLE: begin
                        if (start) begin
                            st_r <= RTM_LOAD;
                            busy <= 1'b1;
                        end
                    end
                    RTM_LOAD: begin
                        if (fifo_valid) begin
                            sh_r <= fifo_data;
                            last_r <= fifo_last;
                            fifo_pop <= 1'b1;
                            bit_r <= 3'h7;
                            cnt_r <= 16'(BIT_CYC - 1);
                            tx_bit <= fifo_data[7];
                            st_r <= RTM_SHIFT;
                        end
                    end
                    RTM_SHIFT: begin
                        if (cnt_r != 16'h0000) begin
                            cnt_r <= cnt_r - 16'h0001;
                        end else if (bit_r != 3'h0) begin
                            bit_r <= bit_r - 3'h1;
                            sh_r <= {sh_r[6:0], 1'b0};
                            tx_bit <= sh_r[6];
                            cnt_r <= 16'(BIT_CYC - 1);
                        end else if (last_r) begin
                            st_r <= RTM_IDLE;
                            busy <= 1'b0;
                            tx_bit <= 1'b0;
                            done <= 1'b1;
                        end else begin
                            st_r <= RTM_LOAD;
                        end
                    end
                endcase
            end
        end
    end
endmodule

/* File: sim/rtm_ctrl_props.sv */
// Checker for the transmit mode control block.
// Assumes it is bound to rtm_ctrl and sees only that module's ports.
`timescale 1ns/1ps
module rtm_ctrl_props #(
    parameter int BIT_CYC = 2
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hrdata,
    input wire logic [7:0] fifo_data,
    input wire logic fifo_valid,
    input wire logic fifo_last,
    input wire logic fifo_pop,
    input wire logic irq_ack,
    input wire logic burst_done_irq,
    input wire rtm_pkg::rtm_afe_t afe
);
    import rtm_pkg::*;
    // ==========================================================
    // Helper state.
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    localparam int BYTE_LO = 8 * BIT_CYC - 4;
    localparam int BYTE_HI = 8 * BIT_CYC + 8;
    logic [1:0] hush_r;
    logic [7:0] byte_r;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hush_r <= 2'h0;
        end else if (irq_ack || (hsel && htrans[1] && hwrite)) begin
            hush_r <= 2'h3;
        end else if (hush_r != 2'h0) begin
            hush_r <= hush_r - 2'h1;
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            byte_r <= 8'h00;
        end else if (fifo_pop) begin
            byte_r <= fifo_data;
        end
    end
    // ==========================================================
    // Properties.
    AST_RESET_VAL: assert property ($rose(hresetn) |-> ##[0:2] (afe.crystal_freq_sel == 3'h3
        && !afe.ref_halve_sel && afe.deviation_word == 11'h190)) else $error("bad reset value");
    AST_OOK_GATE: assert property (!afe.fsk_mode && afe.pa_en |-> afe.tx_bit)
        else $error("amplifier on for a zero");
    AST_POP_GAP: assert property (fifo_pop |=> !fifo_pop [*8]) else $error("pops too close");
    AST_POP_VALID: assert property (fifo_pop |-> $past(fifo_valid)) else $error("pop w/o byte");
    AST_MSB_FIRST: assert property (fifo_pop |=> ##[0:3] (afe.tx_bit == byte_r[7]))
        else $error("first bit not msb");
    AST_DONE_TIME: assert property (fifo_pop && fifo_last |-> ##[BYTE_LO:BYTE_HI]
        $rose(burst_done_irq)) else $error("completion late");
    AST_IRQ_HOLD: assert property (burst_done_irq && !irq_ack && hush_r == 2'h0 |=> burst_done_irq)
        else $error("pending lost");
    AST_IRQ_ACK: assert property (irq_ack && burst_done_irq |-> ##[1:2] !burst_done_irq)
        else $error("ack ignored");
    AST_RDATA_UPPER: assert property (hrdata[31:8] == 24'h0) else $error("upper bits set");
endmodule

bind rtm_ctrl rtm_ctrl_props #(.BIT_CYC(BIT_CYC)) u_props (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hrdata(hrdata), .fifo_data(fifo_data),
    .fifo_valid(fifo_valid), .fifo_last(fifo_last), .fifo_pop(fifo_pop), .irq_ack(irq_ack),
    .burst_done_irq(burst_done_irq), .afe(afe));

/* File: sim/rtm_fifo_model.sv */
// Byte source standing in for the transmit FIFO.
// Assumes the bench loads a packet length and may stall the source.
`timescale 1ns/1ps
module rtm_fifo_model (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic load,
    input wire logic [3:0] len,
    input wire logic stall,
    input wire logic fifo_pop,
    output logic [7:0] fifo_data,
    output logic fifo_valid,
    output logic fifo_last
);
    // ==========================================================
    // Packet pointer; a released data bus shows the inverse of the last byte.
    logic [3:0] idx_r;
    logic [7:0] last_r;
    logic [7:0] cur;
    assign cur = 8'h3c + {idx_r, 4'h5};
    assign fifo_valid = !stall && idx_r < len;
    assign fifo_last = fifo_valid && idx_r == len - 4'h1;
    assign fifo_data = fifo_valid ? cur : ~last_r;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            idx_r <= 4'hf;
            last_r <= 8'h00;
        end else if (load) begin
            idx_r <= 4'h0;
        end else if (fifo_pop && idx_r < len) begin
            idx_r <= idx_r + 4'h1;
            last_r <= cur;
        end
    end
endmodule

/* File: sim/rtm_ctrl_tb.sv */
// Self-checking bench for the transmit mode control block.
// Assumes the bound checker and the FIFO byte source model.
`timescale 1ns/1ps
module rtm_ctrl_tb;
    import rtm_pkg::*;
    // ==========================================================
    // Signals.
    localparam int BC = 2;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b1;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic hready, hreadyout, hresp, fifo_valid, fifo_last, fifo_pop, burst_done_irq, r;
    logic [31:0] hrdata;
    logic [7:0] fifo_data;
    logic [10:0] dv;
    logic irq_ack = 1'b0, load = 1'b0, stall = 1'b0, dp_rd = 1'b0;
    logic [3:0] len = 4'h0;
    logic [2:0] codes [4] = '{3'h0, 3'h1, 3'h3, 3'h4};
    rtm_afe_t afe;
    logic [31:0] exp_q[$];
    int n_errors = 0, samples_checked = 0, cyc = 0, seed = 83349;
    assign hready = hreadyout;
    always #10 hclk = ~hclk;
    rtm_ctrl #(.BIT_CYC(BC)) DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .fifo_data(fifo_data),
        .fifo_valid(fifo_valid), .fifo_last(fifo_last), .fifo_pop(fifo_pop),
        .irq_ack(irq_ack), .burst_done_irq(burst_done_irq), .afe(afe));
    rtm_fifo_model u_fifo (.hclk(hclk), .hresetn(hresetn), .load(load), .len(len),
        .stall(stall), .fifo_pop(fifo_pop), .fifo_data(fifo_data), .fifo_valid(fifo_valid),
        .fifo_last(fifo_last));
    // ==========================================================
    // Tasks.
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        samples_checked++;
        if (seen !== want) begin
            n_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, want);
        end
    endtask
    task automatic close_out();
        $display("Checks %0d, mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge hclk);
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        if (!w) begin
            exp_q.push_back(d);
            dp_rd <= 1'b1;
        end
        do @(posedge hclk); while (hready !== 1'b1);
        dp_rd <= 1'b0;
    endtask
    task automatic cycles(input int n);
        repeat (n) @(posedge hclk);
        #1;
    endtask
    task automatic reload(input logic [3:0] n, input logic s);
        @(posedge hclk);
        len <= n;
        load <= 1'b1;
        stall <= s;
        @(posedge hclk);
        load <= 1'b0;
    endtask
    // ==========================================================
    // Read data monitor and timeout.
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (dp_rd && hready) begin
            check(hrdata, exp_q.pop_front());
            check(32'(hresp), 32'h0);
        end
        if (cyc == 5000) begin
            n_errors++;
            close_out();
        end
    end
    // ==========================================================
    // Main sequence.
    initial begin
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        bus(RTM_OFF_XO_CTRL, 1'b0, 32'h23);
        bus(RTM_OFF_OPER, 1'b0, 32'h0);
        bus(RTM_OFF_DEV_LO, 1'b0, 32'h90);
        bus(RTM_OFF_DEV_HI, 1'b0, 32'h1);
        bus(8'h1c, 1'b0, 32'h0);
        for (int i = 0; i < 4; i++) begin
            r = 1'($random(seed));
            bus(RTM_OFF_XO_CTRL, 1'b1, {24'hffffff, 3'h5, 1'b1, r, codes[i]});
            bus(RTM_OFF_XO_CTRL, 1'b0, {25'h0, 2'h1, 1'b0, r, codes[i]});
            cycles(2);
            check({afe.ref_halve_sel, afe.crystal_freq_sel}, {r, codes[i]});
        end
        bus(RTM_OFF_XO_CTRL, 1'b1, 32'h23);
        bus(RTM_OFF_XO_CTRL, 1'b0, 32'h23);
        dv = 11'($random(seed));
        bus(RTM_OFF_DEV_LO, 1'b1, {24'h0, dv[7:0]});
        bus(RTM_OFF_DEV_HI, 1'b1, {29'h1fffffff, dv[10:8]});
        bus(RTM_OFF_DEV_HI, 1'b0, {29'h0, dv[10:8]});
        cycles(2);
        check(afe.deviation_word, dv);
        dv = 11'(((2 ** 17 - 1) * 50) / 16000);
        bus(RTM_OFF_DEV_LO, 1'b1, {24'h0, dv[7:0]});
        bus(RTM_OFF_DEV_HI, 1'b1, {29'h0, dv[10:8]});
        cycles(2);
        check(afe.deviation_word, dv);
        for (int k = 0; k < 16; k++) begin
            bus(RTM_OFF_OPER, 1'b1, {24'hff, 2'h3, k[0], 5'h1f});
            bus(RTM_OFF_FIFO4, 1'b1, {24'hff, k[1], 7'h7f});
            bus(RTM_OFF_OPMODE, 1'b1, {31'h0, k[2]});
            bus(RTM_OFF_OPMODE, 1'b1, {30'h3fffffff, k[3], k[2]});
            bus(RTM_OFF_OPER, 1'b0, {26'h0, k[0], 5'h10});
            bus(RTM_OFF_FIFO4, 1'b0, {24'h0, k[1], 7'h0});
            bus(RTM_OFF_OPMODE, 1'b0, {30'h0, k[3], k[2]});
            cycles(2);
            check({afe.synth_en, afe.pa_en, afe.tx_bit, afe.fsk_mode},
                {k[2], k[2] & k[3] & (k[0] | k[1]), k[1], k[0]});
        end
        for (int n = 1; n < 3; n++) begin
            reload(n[3:0], 1'b1);
            bus(RTM_OFF_OPER, 1'b1, {26'h0, n[0], 5'h01});
            bus(RTM_OFF_OPER, 1'b0, {26'h0, n[0], 5'h01});
            bus(RTM_OFF_STATUS, 1'b0, 32'h2);
            stall <= 1'b0;
            for (int t = 0; t < 200 && burst_done_irq !== 1'b1; t++) @(posedge hclk);
            #1;
            check(burst_done_irq, 1'b1);
            bus(RTM_OFF_OPER, 1'b0, {26'h0, n[0], 5'h00});
            bus(RTM_OFF_STATUS, 1'b0, 32'h1);
            check({afe.synth_en, afe.pa_en}, 2'h0);
            if (n == 1) begin
                @(posedge hclk);
                irq_ack <= 1'b1;
                @(posedge hclk);
                irq_ack <= 1'b0;
            end else
                bus(RTM_OFF_STATUS, 1'b1, 32'h1);
            cycles(2);
            check(burst_done_irq, 1'b0);
        end
        reload(4'h3, 1'b0);
        bus(RTM_OFF_OPER, 1'b1, 32'h21);
        cycles(12);
        bus(RTM_OFF_OPER, 1'b1, 32'h20);
        cycles(60);
        check(burst_done_irq, 1'b0);
        bus(RTM_OFF_OPER, 1'b0, 32'h20);
        bus(RTM_OFF_STATUS, 1'b0, 32'h0);
        close_out();
    end
endmodule
